/* hdl/ext_regulator_config_control.sv */
`timescale 1ns/100ps
`default_nettype none

module ext_regulator_config_control (
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire logic                      softReset,
    input  wire ext_rail_pkg::chip_mode_e  chipMode,
    input  wire ext_rail_pkg::ctrl_s       ctrl,
    input  wire logic                      ctrlWrite,
    input  wire logic                      batteryLowThreshold,
    input  wire logic                      baseCurrentAboveRise,
    input  wire logic                      baseCurrentBelowFall,
    input  wire logic                      shuntThresholdReached,
    input  wire logic                      railUndervoltage,
    input  wire logic                      overcurrentClear,
    input  wire logic                      undervoltageClear,
    output logic                           externalRailEnable,
    output logic                           outLevel,
    output logic                           highStageEnable,
    output logic                           lowStageEnable,
    output logic                           commandFault,
    output ext_rail_pkg::status_s          status
);

    ////////////////////////////////////////////////////////////////////////////
    // Configuration lock
    ////////////////////////////////////////////////////////////////////////////

    // The lock is taken once per power cycle; a soft reset leaves it alone,
    // so a host that restarts its own software cannot reconfigure the rail.
    // Control bits below the lock are volatile and do clear on soft reset.
    ext_rail_pkg::cfg_state_e cfg_reg;
    ext_rail_pkg::cfg_state_e cfg_next;
    logic                     level_reg;
    logic                     level_next;
    logic                     keep_reg;
    logic                     stopKeep_reg;
    logic                     aloneOn_reg;
    logic                     aloneOn_next;
    logic                     railOn_reg;
    logic                     railOn_next;
    logic                     high_reg;
    logic                     high_next;
    logic                     fault_reg;
    logic                     oc_reg;
    logic                     uv_reg;
    logic                     keep_next;
    logic                     stopKeep_next;
    logic                     fault_next;
    logic                     oc_next;
    logic                     uv_next;
    ext_rail_pkg::status_s    status_reg;
    ext_rail_pkg::status_s    status_next;

    // Mode decode; a code that is not one-hot matches none of these
    wire logic isNormal  = (chipMode == ext_rail_pkg::MODE_NORMAL);
    wire logic isStop    = (chipMode == ext_rail_pkg::MODE_STOP);
    wire logic isSleep   = (chipMode == ext_rail_pkg::MODE_SLEEP);
    wire logic isRestart = (chipMode == ext_rail_pkg::MODE_RESTART);
    wire logic isOff     = (chipMode == ext_rail_pkg::MODE_INIT) ||
                           (chipMode == ext_rail_pkg::MODE_FAILSAFE);
    wire logic isOpen    = (cfg_reg == ext_rail_pkg::CFG_OPEN);
    wire logic isAlone   = (cfg_reg == ext_rail_pkg::CFG_ALONE);
    wire logic isShare   = (cfg_reg == ext_rail_pkg::CFG_SHARE);

    // A write that tries to move the configuration away from the lock
    wire logic changeTry = ctrlWrite && !isOpen &&
                           ((ctrl.shareEnable != isShare) ||
                            (isShare && ctrl.standaloneEnable));

    wire logic faultSet  = changeTry && isShare;

    wire logic pickShare = ctrlWrite && ctrl.shareEnable;

    wire logic pickAlone = ctrlWrite && ctrl.standaloneEnable && isNormal;

    // Next lock state; share wins if both bits arrive together
    always_comb begin
        cfg_next = cfg_reg;
        unique case (cfg_reg)
            ext_rail_pkg::CFG_OPEN: begin
                if (pickShare) begin
                    cfg_next = ext_rail_pkg::CFG_SHARE;
                end else if (pickAlone) begin
                    cfg_next = ext_rail_pkg::CFG_ALONE;
                end
            end
            ext_rail_pkg::CFG_ALONE: cfg_next = ext_rail_pkg::CFG_ALONE;
            ext_rail_pkg::CFG_SHARE: cfg_next = ext_rail_pkg::CFG_SHARE;
        endcase
    end

    // lock cleared by power reset only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_reg <= ext_rail_pkg::CFG_RESET;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control bits and rail state
    ////////////////////////////////////////////////////////////////////////////

    // level from select bit, sharing forces 5.0V
    assign level_next = !ctrlWrite ? level_reg :
                        (isShare || cfg_next == ext_rail_pkg::CFG_SHARE) ?
                        ext_rail_pkg::LEVEL_5V0 : ctrl.outLevelSelect;

    // Stand-alone on/off is only switchable in normal mode; else held.
    // A write in another mode leaves the rail as it was, which keeps the
    // fixed behaviour of stop, sleep and restart intact.
    assign aloneOn_next = (ctrlWrite && isNormal) ? ctrl.standaloneEnable : aloneOn_reg;

    assign keep_next     = ctrlWrite ? ctrl.keepOnLowSupply : keep_reg;
    assign stopKeep_next = ctrlWrite ? ctrl.shareInStop : stopKeep_reg;

    // Control bits are cleared by soft reset, the lock is not
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            level_reg    <= ext_rail_pkg::LEVEL_5V0;
            keep_reg     <= ext_rail_pkg::CTRL_BIT_RESET;
            stopKeep_reg <= ext_rail_pkg::CTRL_BIT_RESET;
            aloneOn_reg  <= ext_rail_pkg::CTRL_BIT_RESET;
        end else if (softReset) begin
            level_reg    <= ext_rail_pkg::LEVEL_5V0;
            keep_reg     <= ext_rail_pkg::CTRL_BIT_RESET;
            stopKeep_reg <= ext_rail_pkg::CTRL_BIT_RESET;
            aloneOn_reg  <= ext_rail_pkg::CTRL_BIT_RESET;
        end else begin
            level_reg    <= level_next;
            keep_reg     <= keep_next;
            stopKeep_reg <= stopKeep_next;
            aloneOn_reg  <= aloneOn_next;
        end
    end

    // Modes in which a stand-alone rail keeps its last state
    wire logic isHold    = isStop || isSleep || isRestart;

    // stand-alone per mode: off, configurable, or fixed
    // An illegal mode code falls back to off, the safe side for a load
    wire logic aloneWant = isOff    ? ext_rail_pkg::RAIL_OFF :
                           isNormal ? aloneOn_next :
                           isHold   ? railOn_reg : ext_rail_pkg::RAIL_OFF;

    // sharing follows main rail, stop gated by keep bit
    wire logic shareWant = isNormal || isRestart || (isStop && stopKeep_reg);

    wire logic uvBlock   = batteryLowThreshold && !keep_reg;

    assign railOn_next = isAlone ? aloneWant :
                         isShare ? shareWant : ext_rail_pkg::RAIL_OFF;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            railOn_reg <= ext_rail_pkg::RAIL_OFF;
        end else begin
            railOn_reg <= railOn_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Regulator stages
    ////////////////////////////////////////////////////////////////////////////

    // Rising comparator wins a tie, so a load step is never starved.
    // Outside normal and stop the low stage carries the rail alone.
    // stop-mode hysteresis on base current
    always_comb begin
        high_next = high_reg;
        if (isNormal) begin
            high_next = 1'h1;
        end else if (!isStop) begin
            high_next = 1'h0;
        end else if (baseCurrentAboveRise) begin
            high_next = 1'h1;
        end else if (baseCurrentBelowFall) begin
            high_next = 1'h0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            high_reg <= ext_rail_pkg::STAGE_RESET;
        end else begin
            high_reg <= high_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags
    ////////////////////////////////////////////////////////////////////////////

    // sticky overcurrent, stand-alone only; set beats clear
    wire logic ocSet = isAlone && railOn_reg && shuntThresholdReached;
    // Rail undervoltage is only signalled in stand-alone configuration
    wire logic uvSet = isAlone && railOn_reg && railUndervoltage;

    assign fault_next = faultSet || (fault_reg && !ctrlWrite);
    assign oc_next    = ocSet || (oc_reg && !overcurrentClear);
    assign uv_next    = uvSet || (uv_reg && !undervoltageClear);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fault_reg <= ext_rail_pkg::FLAG_RESET;
            oc_reg    <= ext_rail_pkg::FLAG_RESET;
            uv_reg    <= ext_rail_pkg::FLAG_RESET;
        end else begin
            fault_reg <= fault_next;
            oc_reg    <= oc_next;
            uv_reg    <= uv_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////////////////

    // Battery undervoltage acts without a clock delay, so the rail drops at once
    wire logic railLive = railOn_reg && !uvBlock;

    // Stage enables only run while the rail itself is live
    assign externalRailEnable = railLive;
    assign outLevel           = level_reg;
    assign highStageEnable    = railLive && high_reg;
    assign lowStageEnable     = railLive && !isNormal;
    assign commandFault       = fault_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Status word
    ////////////////////////////////////////////////////////////////////////////

    assign status_next = '{railOn:              railLive,
                           configAlone:         isAlone,
                           configShare:         isShare,
                           extOvercurrentFlag:  oc_reg,
                           extUndervoltageFlag: uv_reg};

    // Registered, so the host sees settled bits one clock after the rail moves
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status_reg <= ext_rail_pkg::STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    assign status = status_reg;

    // Notes for users of this block:
    // - outLevel only matters in stand-alone configuration; while sharing
    //   it reads 5.0V and the main rail decides the real level.
    // - Soft reset leaves both flags alone; only the host clears them.
    // - commandFault clears on the next accepted write, so a host that
    //   polls it must read it before its next configuration write.
    // - The status word lags externalRailEnable by one clock.
    // - An illegal mode code turns a stand-alone rail off and keeps the
    //   high stage off; sharing also stays off in that case.

endmodule : ext_regulator_config_control

`default_nettype wire

/* include/ext_rail_pkg.sv */
`default_nettype none
package ext_rail_pkg;

    // Chip operating modes, one-hot
    typedef enum logic [5:0] {
        MODE_INIT    = 6'h01,
        MODE_NORMAL  = 6'h02,
        MODE_STOP    = 6'h04,
        MODE_SLEEP   = 6'h08,
        MODE_RESTART = 6'h10,
        MODE_FAILSAFE= 6'h20
    } chip_mode_e;

    // Locked configuration states, one-hot
    typedef enum logic [2:0] {
        CFG_OPEN     = 3'h1,
        CFG_ALONE    = 3'h2,
        CFG_SHARE    = 3'h4
    } cfg_state_e;

    // Host control bits as one bundle
    typedef struct packed {
        logic standaloneEnable;
        logic shareEnable;
        logic outLevelSelect;
        logic keepOnLowSupply;
        logic shareInStop;
    } ctrl_s;

    // Status seen by the host in the second supply status word
    typedef struct packed {
        logic railOn;
        logic configAlone;
        logic configShare;
        logic extOvercurrentFlag;
        logic extUndervoltageFlag;
    } status_s;

    localparam logic       LEVEL_5V0      = 1'h0;
    localparam logic       LEVEL_3V3      = 1'h1;
    localparam logic       RAIL_OFF       = 1'h0;
    localparam logic       RAIL_ON        = 1'h1;
    localparam cfg_state_e CFG_RESET      = CFG_OPEN;
    localparam logic       CTRL_BIT_RESET = 1'h0;
    localparam logic       FLAG_RESET     = 1'h0;
    localparam logic       STAGE_RESET    = 1'h0;
    localparam status_s    STATUS_RESET   = 5'h00;

endpackage : ext_rail_pkg
`default_nettype wire

/* tb/ext_regulator_config_control_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module ext_regulator_config_control_sva (
    input wire logic                     clk,
    input wire logic                     reset,
    input wire logic                     softReset,
    input wire ext_rail_pkg::chip_mode_e chipMode,
    input wire ext_rail_pkg::ctrl_s      ctrl,
    input wire logic                     ctrlWrite,
    input wire logic                     batteryLowThreshold,
    input wire logic                     baseCurrentAboveRise,
    input wire logic                     externalRailEnable,
    input wire logic                     outLevel,
    input wire logic                     highStageEnable,
    input wire logic                     lowStageEnable,
    input wire logic                     commandFault,
    input wire ext_rail_pkg::status_s    status
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Mirror of the keep-on bit as the host last wrote it
    logic keepSeen;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) keepSeen <= 1'h0;
        else if (softReset) keepSeen <= 1'h0;
        else if (ctrlWrite) keepSeen <= ctrl.keepOnLowSupply;
    end
    // Steps: a write that tries to move a shared lock, heavy load held in stop
    sequence shareChange;
        status.configShare && ctrlWrite && (!ctrl.shareEnable || ctrl.standaloneEnable);
    endsequence
    sequence stopHeavy;
        chipMode == ext_rail_pkg::MODE_STOP && baseCurrentAboveRise;
    endsequence
    chk_share_fault: assert property (shareChange |=> commandFault)
        else $error("no fault after change of shared rail");
    chk_alone_nofault: assert property (status.configAlone && ctrlWrite |=> !commandFault)
        else $error("fault raised with stand-alone lock");
    chk_alone_lock: assert property (status.configAlone |=> status.configAlone && !status.configShare)
        else $error("stand-alone lock lost");
    chk_share_lock: assert property (status.configShare |=> status.configShare && !status.configAlone)
        else $error("share lock lost");
    chk_share_level: assert property (status.configShare |-> outLevel == ext_rail_pkg::LEVEL_5V0)
        else $error("level select used while sharing");
    chk_uv_off: assert property (batteryLowThreshold && !keepSeen |-> !externalRailEnable)
        else $error("rail on during battery undervoltage");
    chk_rail_status: assert property (status.railOn == $past(externalRailEnable))
        else $error("status rail bit differs from rail enable");
    chk_init_off: assert property ((chipMode == ext_rail_pkg::MODE_INIT || chipMode == ext_rail_pkg::MODE_FAILSAFE) && $past(chipMode) == chipMode |-> !externalRailEnable)
        else $error("rail on in init or fail-safe");
    chk_normal_stage: assert property (chipMode == ext_rail_pkg::MODE_NORMAL && $past(chipMode) == chipMode && externalRailEnable |-> highStageEnable && !lowStageEnable)
        else $error("wrong stages in normal mode");
    chk_stop_rise: assert property (stopHeavy ##1 (stopHeavy and externalRailEnable) |-> highStageEnable)
        else $error("high stage off under heavy stop load");
    chk_share_oc: assert property (status.configShare |-> !status.extOvercurrentFlag)
        else $error("overcurrent flagged while sharing");
endmodule : ext_regulator_config_control_sva
bind ext_regulator_config_control ext_regulator_config_control_sva i_sva (
    .clk(clk), .reset(reset), .softReset(softReset), .chipMode(chipMode), .ctrl(ctrl),
    .ctrlWrite(ctrlWrite),
    .batteryLowThreshold(batteryLowThreshold), .baseCurrentAboveRise(baseCurrentAboveRise),
    .externalRailEnable(externalRailEnable), .outLevel(outLevel),
    .highStageEnable(highStageEnable), .lowStageEnable(lowStageEnable),
    .commandFault(commandFault), .status(status));
`default_nettype wire

/* tb/ext_rail_load_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ext_rail_load_model (
    input  wire logic       railEnable,
    input  wire logic [1:0] loadLevel,
    input  wire logic       shortCircuit,
    output logic            aboveRise,
    output logic            belowFall,
    output logic            shuntHit,
    output logic            railLow
);
    assign aboveRise = railEnable && loadLevel == 2'h2;
    assign belowFall = !railEnable || loadLevel == 2'h0;
    assign shuntHit = railEnable && shortCircuit;
    assign railLow  = railEnable && shortCircuit;
endmodule : ext_rail_load_model
`default_nettype wire

/* tb/ext_regulator_config_control_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module ext_regulator_config_control_tb;
    logic clk, reset, softReset, ctrlWrite, batLow, ocClr, uvClr, shortCirc;
    logic hi, lo, fault, railEn, outLevel, above, below, shunt, railUv;
    logic [1:0] load;
    ext_rail_pkg::chip_mode_e chipMode;
    ext_rail_pkg::ctrl_s ctrl;
    ext_rail_pkg::status_s status;
    int n_errors = 0;
    int checks = 0;
    ext_regulator_config_control i_dut (.clk(clk), .reset(reset), .softReset(softReset),
        .chipMode(chipMode), .ctrl(ctrl), .ctrlWrite(ctrlWrite), .batteryLowThreshold(batLow),
        .baseCurrentAboveRise(above), .baseCurrentBelowFall(below),
        .shuntThresholdReached(shunt), .railUndervoltage(railUv), .overcurrentClear(ocClr),
        .undervoltageClear(uvClr), .externalRailEnable(railEn), .outLevel(outLevel),
        .highStageEnable(hi), .lowStageEnable(lo), .commandFault(fault), .status(status));
    ext_rail_load_model i_load (.railEnable(railEn), .loadLevel(load), .shortCircuit(shortCirc),
        .aboveRise(above), .belowFall(below), .shuntHit(shunt), .railLow(railUv));
    task automatic eq(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : eq
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic wr(input logic [4:0] c);
        ctrl = c;
        ctrlWrite = 1'b1;
        tick(1);
        ctrlWrite = 1'b0;
        tick(1);
    endtask : wr
    task automatic md(input ext_rail_pkg::chip_mode_e m);
        chipMode = m;
        tick(2);
    endtask : md
    task automatic end_of_test;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        end_of_test();
    end
    initial begin
        {reset, softReset, ctrlWrite, batLow, ocClr, uvClr, shortCirc, load} = 9'h100;
        ctrl = '0;
        chipMode = ext_rail_pkg::MODE_INIT;
        tick(20);
        reset = 1'b0;
        md(ext_rail_pkg::MODE_NORMAL);
        wr(5'h14);
        eq(status.configAlone, 1'b1);
        eq(outLevel, 1'b1);
        wr(5'h08);
        eq(status.configShare, 1'b0);
        eq(fault, 1'b0);
        eq(railEn, 1'b0);
        wr(5'h12);
        batLow = 1'b1;
        tick(1);
        eq(railEn, 1'b1);
        wr(5'h10);
        eq(railEn, 1'b0);
        batLow = 1'b0;
        tick(1);
        eq(railEn, 1'b1);
        eq(outLevel, 1'b0);
        softReset = 1'b1;
        tick(1);
        softReset = 1'b0;
        tick(1);
        eq(status.configAlone, 1'b1);
        wr(5'h10);
        shortCirc = 1'b1;
        tick(2);
        ocClr = 1'b1;
        tick(1);
        ocClr = 1'b0;
        tick(1);
        eq(status.extOvercurrentFlag, 1'b1);
        eq(status.extUndervoltageFlag, 1'b1);
        shortCirc = 1'b0;
        {ocClr, uvClr} = 2'h3;
        tick(1);
        {ocClr, uvClr} = 2'h0;
        tick(1);
        eq(status.extOvercurrentFlag, 1'b0);
        eq(status.extUndervoltageFlag, 1'b0);
        md(ext_rail_pkg::MODE_STOP);
        load = 2'h2;
        tick(3);
        eq(hi, 1'b1);
        eq(lo, 1'b1);
        load = 2'h0;
        tick(3);
        eq(hi, 1'b0);
        md(ext_rail_pkg::MODE_NORMAL);
        eq(hi, 1'b1);
        eq(lo, 1'b0);
        md(ext_rail_pkg::MODE_SLEEP);
        eq(railEn, 1'b1);
        md(ext_rail_pkg::MODE_INIT);
        eq(railEn, 1'b0);
        $display("test stand-alone done");
        reset = 1'b1;
        tick(2);
        reset = 1'b0;
        md(ext_rail_pkg::MODE_NORMAL);
        wr(5'h0C);
        eq(status.configShare, 1'b1);
        eq(outLevel, 1'b0);
        eq(railEn, 1'b1);
        wr(5'h10);
        eq(fault, 1'b1);
        eq(status.configAlone, 1'b0);
        shortCirc = 1'b1;
        tick(2);
        eq(status.extOvercurrentFlag, 1'b0);
        eq(status.extUndervoltageFlag, 1'b0);
        shortCirc = 1'b0;
        md(ext_rail_pkg::MODE_STOP);
        eq(railEn, 1'b0);
        md(ext_rail_pkg::MODE_NORMAL);
        eq(railEn, 1'b1);
        wr(5'h09);
        md(ext_rail_pkg::MODE_STOP);
        eq(railEn, 1'b1);
        md(ext_rail_pkg::MODE_SLEEP);
        eq(railEn, 1'b0);
        md(ext_rail_pkg::MODE_RESTART);
        eq(railEn, 1'b1);
        eq(status.railOn, 1'b1);
        md(ext_rail_pkg::MODE_FAILSAFE);
        eq(railEn, 1'b0);
        eq(status.railOn, 1'b0);
        $display("test sharing done");
        end_of_test();
    end
endmodule : ext_regulator_config_control_tb
`default_nettype wire
